// File: design/ira_boot_store.sv
// Boot progress store: 32 bytes filled through the dedicated boot ports.
// Assumes one write strobe per clock at most; reads are combinational.
`timescale 1ns/10ps
module ira_boot_store #(
	parameter int DEPTH = 32
) (
	input  wire logic                     clock,     // System clock
	input  wire logic                     rst_n,     // Async reset, low
	input  wire logic                     boot_wr,   // Boot port write
	input  wire logic [7:0]               boot_wdata,// Boot code byte
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,   // Read location
	output logic      [7:0]               rd_data,   // Read byte
	output logic                          overflow   // Top slot written
);

	logic [7:0]               mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] wptr_ff;
	logic                     full_ff;

	localparam logic [$clog2(DEPTH)-1:0] TOP = ($clog2(DEPTH))'(DEPTH - 1);

	////////////////////////////////////////////////////////////////////////
	// Once the top slot is written further bytes are dropped so the early
	// codes, which matter most when a boot hangs, are never overwritten.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wptr_ff <= '0;
			full_ff <= 1'b0;
		end else if (boot_wr && !full_ff) begin
			if (wptr_ff == TOP) begin
				full_ff <= 1'b1;
			end else begin
				wptr_ff <= wptr_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (boot_wr && !full_ff) begin
			mem[wptr_ff] <= boot_wdata;
		end
	end

	assign overflow = boot_wr && !full_ff && (wptr_ff == TOP);
	assign rd_data  = mem[rd_addr];

endmodule

// File: design/ira_pkg.sv
// Constants shared by the indexed register access front end.
// Assumes a byte wide host bus decoded down to a three bit port number.
package ira_pkg;

	// Host port numbers (low address bits of the parallel bus)
	localparam logic [2:0] IRA_PORT_BOOT_A = 3'h0;
	localparam logic [2:0] IRA_PORT_BOOT_B = 3'h4;
	localparam logic [2:0] IRA_PORT_INDEX  = 3'h5;
	localparam logic [2:0] IRA_PORT_DATA   = 3'h6;

	// Index register layout
	localparam int IRA_BUSY_BIT = 7;
	localparam int IRA_PTR_W    = 7;

	// Internal register addresses
	localparam logic [6:0] IRA_A_CONFIG    = 7'h40;
	localparam logic [6:0] IRA_A_EVT_FIRST = 7'h41;
	localparam logic [6:0] IRA_A_EVT_SECND = 7'h42;
	localparam logic [6:0] IRA_A_MGMT_M1   = 7'h43;
	localparam logic [6:0] IRA_A_MGMT_M2   = 7'h44;
	localparam logic [6:0] IRA_A_HOST_M1   = 7'h45;
	localparam logic [6:0] IRA_A_HOST_M2   = 7'h46;
	localparam logic [6:0] IRA_A_VID_FAN   = 7'h47;
	localparam logic [6:0] IRA_A_SER_ADDR  = 7'h48;
	localparam logic [6:0] IRA_A_CHIP_ID   = 7'h49;

	// Address ranges
	localparam logic [6:0] IRA_BOOT_TOP    = 7'h1f;
	localparam logic [6:0] IRA_VAL_LO_BASE = 7'h20;
	localparam logic [6:0] IRA_VAL_LO_TOP  = 7'h3f;
	localparam logic [6:0] IRA_VAL_HI_BASE = 7'h60;
	localparam logic [6:0] IRA_VAL_HI_TOP  = 7'h7f;
	localparam logic [6:0] IRA_PTR_STEP    = 7'h01;

	// Reset values
	localparam logic [7:0] IRA_RST_INDEX   = 8'h00;
	localparam logic [7:0] IRA_RST_CONFIG  = 8'h08;
	localparam logic [7:0] IRA_RST_ZERO    = 8'h00;
	localparam logic [7:0] IRA_RST_HOST_M2 = 8'h40;
	localparam logic [3:0] IRA_RST_FAN_DIV = 4'h5;
	localparam logic [7:0] IRA_RST_SER     = 8'h2d;

	// Field positions
	localparam int IRA_CFG_INIT_BIT = 7;
	localparam int IRA_EVT2_OVF_BIT = 5;
	localparam logic [7:0] IRA_EVT2_USED = 8'h7f;

endpackage

// File: design/ira_top.sv
// Indexed register access front end: index port, data port, register map.
// Assumes the host bus gives one-cycle read and write strobes.
// What this block does
// - Index port holds a read/write 7-bit pointer selecting the data target
// - Reset clears the pointer and the busy flag
// - Index bit 7 is a read-only busy flag for either bus
// - Busy sets on index write and while serial transfer runs
// - Data access clears host busy; serial busy ends with transfer
// - Data access at first event flags moves pointer to second
// - Data access at first management mask moves pointer to second
// - Data access at first host mask moves pointer to second
// - Boot range pointer advances by one, stops at top
// - Upper value range pointer advances by one, stops at top
// - Reading event flags returns then clears them
// - Data port boot reads use index pointer, not boot write pointer
`timescale 1ns/10ps
module ira_top #(
	parameter logic [7:0] CHIP_ID = 8'h00  // Arbitrary identity value
) (
	input  wire logic       clock,          // 200 MHz system clock
	input  wire logic       rst_n,          // Async reset, low
	input  wire logic [2:0] host_port,      // Host port number
	input  wire logic       host_rd,        // Host read strobe
	input  wire logic       host_wr,        // Host write strobe
	input  wire logic [7:0] host_wdata,     // Host write data
	output logic      [7:0] host_rdata,     // Host read data
	input  wire logic       serial_busy,    // Serial transfer running
	input  wire logic [7:0] evt_set_first,  // Monitor sets flags 1
	input  wire logic [7:0] evt_set_second, // Monitor sets flags 2
	input  wire logic [3:0] voltage_id_inputs, // Voltage id pins
	output logic      [7:0] cfg_out,        // Configuration reg
	output logic      [7:0] mgmt_mask_out1, // Mgmt mask 1
	output logic      [7:0] mgmt_mask_out2, // Mgmt mask 2
	output logic      [7:0] host_mask_out1, // Host irq mask 1
	output logic      [7:0] host_mask_out2, // Host irq mask 2
	output logic      [7:0] evt_first_out,  // Event flags 1
	output logic      [7:0] evt_second_out, // Event flags 2
	output logic      [7:0] serial_addr_out,// Serial slave address
	output logic      [3:0] fan_div_out     // Fan divider field
);

	import ira_pkg::*;

	logic [6:0] pointer_bits_ff;
	logic [6:0] nxt_pointer_bits;
	logic       busy_host_ff;
	logic       busy;
	logic [7:0] cfg_ff, mgmt1_ff, mgmt2_ff, host1_ff, host2_ff;
	logic [7:0] evt1_ff, evt2_ff, nxt_evt1, nxt_evt2;
	logic [7:0] ser_ff;
	logic [3:0] fan_ff;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [7:0] val_ram [64];
	logic [7:0] boot_rd;
	logic       boot_ovf;
	logic       idx_wr, data_acc, data_rd, data_wr, boot_wr, init_wr;
	logic       in_val_lo, in_val_hi;
	logic [5:0] val_idx;

	assign idx_wr    = host_wr && host_port == IRA_PORT_INDEX;
	assign data_rd   = host_rd && host_port == IRA_PORT_DATA;
	assign data_wr   = host_wr && host_port == IRA_PORT_DATA;
	assign data_acc  = data_rd || data_wr;
	assign boot_wr   = host_wr && (host_port == IRA_PORT_BOOT_A ||
	                               host_port == IRA_PORT_BOOT_B);
	assign init_wr   = data_wr && pointer_bits_ff == IRA_A_CONFIG &&
	                   host_wdata[IRA_CFG_INIT_BIT];
	assign in_val_lo = pointer_bits_ff >= IRA_VAL_LO_BASE &&
	                   pointer_bits_ff <= IRA_VAL_LO_TOP;
	assign in_val_hi = pointer_bits_ff >= IRA_VAL_HI_BASE;
	assign val_idx   = {in_val_hi, pointer_bits_ff[4:0]};

	////////////////////////////////////////////////////////////////////////
	// boot reads use the index pointer; the store keeps its own write pointer
	ira_boot_store #(
		.DEPTH(32)
	) u_boot (
		.clock      (clock),
		.rst_n      (rst_n),
		.boot_wr    (boot_wr),
		.boot_wdata (host_wdata),
		.rd_addr    (pointer_bits_ff[4:0]),
		.rd_data    (boot_rd),
		.overflow   (boot_ovf)
	);

	////////////////////////////////////////////////////////////////////////
	// Pointer stepping after each data port access
	always_comb begin
		nxt_pointer_bits = pointer_bits_ff;
		if (idx_wr) begin
			nxt_pointer_bits = host_wdata[IRA_PTR_W-1:0];
		end else if (data_acc) begin
			if (pointer_bits_ff == IRA_A_EVT_FIRST) begin
				nxt_pointer_bits = IRA_A_EVT_SECND;
			end else if (pointer_bits_ff == IRA_A_MGMT_M1) begin
				nxt_pointer_bits = IRA_A_MGMT_M2;
			end else if (pointer_bits_ff == IRA_A_HOST_M1) begin
				nxt_pointer_bits = IRA_A_HOST_M2;
			end else if (pointer_bits_ff < IRA_BOOT_TOP) begin
				nxt_pointer_bits = pointer_bits_ff + IRA_PTR_STEP;
			end else if (in_val_hi && pointer_bits_ff != IRA_VAL_HI_TOP) begin
				nxt_pointer_bits = pointer_bits_ff + IRA_PTR_STEP;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pointer_bits_ff <= IRA_RST_INDEX[IRA_PTR_W-1:0];
		end else begin
			pointer_bits_ff <= nxt_pointer_bits;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host busy set and clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_host_ff <= IRA_RST_INDEX[IRA_BUSY_BIT];
		end else if (idx_wr) begin
			busy_host_ff <= 1'b1;
		end else if (data_acc) begin
			busy_host_ff <= 1'b0;
		end
	end

	assign busy = busy_host_ff || serial_busy;

	////////////////////////////////////////////////////////////////////////
	// Writable registers; the init bit restores all but the serial address and the value RAM
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff   <= IRA_RST_CONFIG;
			mgmt1_ff <= IRA_RST_ZERO;
			mgmt2_ff <= IRA_RST_ZERO;
			host1_ff <= IRA_RST_ZERO;
			host2_ff <= IRA_RST_HOST_M2;
			fan_ff   <= IRA_RST_FAN_DIV;
		end else if (init_wr) begin
			cfg_ff   <= IRA_RST_CONFIG;
			mgmt1_ff <= IRA_RST_ZERO;
			mgmt2_ff <= IRA_RST_ZERO;
			host1_ff <= IRA_RST_ZERO;
			host2_ff <= IRA_RST_HOST_M2;
			fan_ff   <= IRA_RST_FAN_DIV;
		end else if (data_wr) begin
			if (pointer_bits_ff == IRA_A_CONFIG) begin
				cfg_ff <= host_wdata;
			end else if (pointer_bits_ff == IRA_A_MGMT_M1) begin
				mgmt1_ff <= host_wdata;
			end else if (pointer_bits_ff == IRA_A_MGMT_M2) begin
				mgmt2_ff <= host_wdata;
			end else if (pointer_bits_ff == IRA_A_HOST_M1) begin
				host1_ff <= host_wdata;
			end else if (pointer_bits_ff == IRA_A_HOST_M2) begin
				host2_ff <= host_wdata;
			end else if (pointer_bits_ff == IRA_A_VID_FAN) begin
				fan_ff <= host_wdata[7:4];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ser_ff <= IRA_RST_SER;
		end else if (data_wr && pointer_bits_ff == IRA_A_SER_ADDR) begin
			ser_ff <= host_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (data_wr && (in_val_lo || in_val_hi)) begin
			val_ram[val_idx] <= host_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read clears flags; a new event in the same cycle survives
	always_comb begin
		nxt_evt1 = evt1_ff;
		nxt_evt2 = evt2_ff;
		if (data_rd && pointer_bits_ff == IRA_A_EVT_FIRST) begin
			nxt_evt1 = IRA_RST_ZERO;
		end
		if (data_rd && pointer_bits_ff == IRA_A_EVT_SECND) begin
			nxt_evt2 = IRA_RST_ZERO;
		end
		nxt_evt1 = nxt_evt1 | evt_set_first;
		nxt_evt2 = (nxt_evt2 | evt_set_second) & IRA_EVT2_USED;
		nxt_evt2[IRA_EVT2_OVF_BIT] = nxt_evt2[IRA_EVT2_OVF_BIT] | boot_ovf;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			evt1_ff <= IRA_RST_ZERO;
			evt2_ff <= IRA_RST_ZERO;
		end else if (init_wr) begin
			evt1_ff <= IRA_RST_ZERO;
			evt2_ff <= IRA_RST_ZERO;
		end else begin
			evt1_ff <= nxt_evt1;
			evt2_ff <= nxt_evt2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data mux, registered one cycle after the strobe
	always_comb begin
		nxt_rdata = rdata_ff;
		if (host_rd && host_port == IRA_PORT_INDEX) begin
			nxt_rdata = {busy, pointer_bits_ff};
		end else if (data_rd) begin
			if (pointer_bits_ff <= IRA_BOOT_TOP) begin
				nxt_rdata = boot_rd;
			end else if (in_val_lo || in_val_hi) begin
				nxt_rdata = val_ram[val_idx];
			end else if (pointer_bits_ff == IRA_A_CONFIG) begin
				nxt_rdata = cfg_ff;
			end else if (pointer_bits_ff == IRA_A_EVT_FIRST) begin
				nxt_rdata = evt1_ff;
			end else if (pointer_bits_ff == IRA_A_EVT_SECND) begin
				nxt_rdata = evt2_ff;
			end else if (pointer_bits_ff == IRA_A_MGMT_M1) begin
				nxt_rdata = mgmt1_ff;
			end else if (pointer_bits_ff == IRA_A_MGMT_M2) begin
				nxt_rdata = mgmt2_ff;
			end else if (pointer_bits_ff == IRA_A_HOST_M1) begin
				nxt_rdata = host1_ff;
			end else if (pointer_bits_ff == IRA_A_HOST_M2) begin
				nxt_rdata = host2_ff;
			end else if (pointer_bits_ff == IRA_A_VID_FAN) begin
				nxt_rdata = {fan_ff, voltage_id_inputs};
			end else if (pointer_bits_ff == IRA_A_SER_ADDR) begin
				nxt_rdata = ser_ff;
			end else if (pointer_bits_ff == IRA_A_CHIP_ID) begin
				nxt_rdata = CHIP_ID;
			end else begin
				nxt_rdata = IRA_RST_ZERO;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= IRA_RST_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign host_rdata      = rdata_ff;
	assign cfg_out         = cfg_ff;
	assign mgmt_mask_out1  = mgmt1_ff;
	assign mgmt_mask_out2  = mgmt2_ff;
	assign host_mask_out1  = host1_ff;
	assign host_mask_out2  = host2_ff;
	assign evt_first_out   = evt1_ff;
	assign evt_second_out  = evt2_ff;
	assign serial_addr_out = ser_ff;
	assign fan_div_out     = fan_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_acc_at(logic [6:0] a);
		data_acc && !idx_wr && pointer_bits_ff == a;
	endsequence

	a_index_load: assert property (@(posedge clock) disable iff (!rst_n)
		idx_wr |=> pointer_bits_ff == $past(host_wdata[6:0]))
		else $error("pointer not loaded from index write");
	a_busy_set: assert property (@(posedge clock) disable iff (!rst_n)
		idx_wr |=> busy ##0 busy_host_ff)
		else $error("busy not set by index write");
	a_busy_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(data_acc && !serial_busy) ##1 !serial_busy |-> !busy)
		else $error("busy not cleared by data access");
	a_busy_read: assert property (@(posedge clock) disable iff (!rst_n)
		(host_rd && host_port == IRA_PORT_INDEX) |=>
		host_rdata == {$past(busy), $past(pointer_bits_ff)})
		else $error("index read shows wrong busy or pointer");
	a_evt_pair: assert property (@(posedge clock) disable iff (!rst_n)
		s_acc_at(IRA_A_EVT_FIRST) |=> pointer_bits_ff == IRA_A_EVT_SECND)
		else $error("event pair step missing");
	a_mgmt_pair: assert property (@(posedge clock) disable iff (!rst_n)
		s_acc_at(IRA_A_MGMT_M1) |=> pointer_bits_ff == IRA_A_MGMT_M2)
		else $error("mgmt pair step missing");
	a_host_pair: assert property (@(posedge clock) disable iff (!rst_n)
		s_acc_at(IRA_A_HOST_M1) |=> pointer_bits_ff == IRA_A_HOST_M2)
		else $error("host mask pair step missing");
	a_boot_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(data_acc && !idx_wr && pointer_bits_ff <= IRA_BOOT_TOP) |=>
		pointer_bits_ff == ($past(pointer_bits_ff) == IRA_BOOT_TOP ?
		IRA_BOOT_TOP : $past(pointer_bits_ff) + IRA_PTR_STEP))
		else $error("boot range step wrong");
	a_value_stop: assert property (@(posedge clock) disable iff (!rst_n)
		s_acc_at(IRA_VAL_HI_TOP) |=> pointer_bits_ff == IRA_VAL_HI_TOP)
		else $error("upper value range wrapped");
	a_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(data_rd && pointer_bits_ff == IRA_A_EVT_FIRST && !init_wr) |=>
		host_rdata == $past(evt1_ff) && evt1_ff == $past(evt_set_first))
		else $error("event flags not returned and cleared");
	a_ptr_hold: assert property (@(posedge clock) disable iff (!rst_n)
		s_acc_at(IRA_A_CONFIG) |=> $stable(pointer_bits_ff))
		else $error("pointer moved at config register");

endmodule

// File: tb/ira_far_model.sv
// Far side model: serial bus master busy level and monitoring loop events.
// Assumes the bench calls its tasks while the host bus is quiet.
`timescale 1ns/10ps
module ira_far_model #(
	parameter logic [3:0] VOLTAGE_ID_INPUTS = 4'h9  // Voltage id pin level
) (
	input  wire logic       clock,             // System clock
	output logic            serial_busy,       // Serial transfer running
	output logic      [7:0] evt_set_first,     // Flag set pulses 1
	output logic      [7:0] evt_set_second,    // Flag set pulses 2
	output logic      [3:0] voltage_id_inputs  // Voltage id pins
);
	initial begin
		serial_busy = 1'b0;
		evt_set_first = 8'h00;
		evt_set_second = 8'h00;
		voltage_id_inputs = VOLTAGE_ID_INPUTS;
	end
	task automatic serial_txn(input int n);
		@(negedge clock);
		serial_busy = 1'b1;
		repeat (n) @(negedge clock);
		serial_busy = 1'b0;
	endtask
	// Single cycle pulses, as the monitoring loop sets flags
	task automatic raise_evt(input logic [7:0] a, input logic [7:0] b);
		@(negedge clock);
		evt_set_first = a;
		evt_set_second = b;
		@(negedge clock);
		evt_set_first = 8'h00;
		evt_set_second = 8'h00;
	endtask
endmodule

// File: tb/ira_top_tb.sv
// Self-checking bench for the indexed register access front end.
// Assumes one-cycle host strobes and registered read data.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	$display("Error t=%0t got %h exp %h", $time, g, e); \
	errors++; end end
module ira_top_tb;
	import ira_pkg::*;
	logic       clock;
	logic       rst_n;
	logic [2:0] host_port;
	logic       host_rd;
	logic       host_wr;
	logic [7:0] host_wdata;
	logic [7:0] host_rdata;
	logic       serial_busy;
	logic [7:0] evt_set_first;
	logic [7:0] evt_set_second;
	logic [3:0] voltage_id_inputs;
	logic [7:0] cfg_out;
	logic [7:0] mgmt_mask_out1;
	logic [7:0] mgmt_mask_out2;
	logic [7:0] host_mask_out1;
	logic [7:0] host_mask_out2;
	logic [7:0] evt_first_out;
	logic [7:0] evt_second_out;
	logic [7:0] serial_addr_out;
	logic [3:0] fan_div_out;
	int         errors;
	int         checks_done;
	logic [7:0] rst_exp [10] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h40, 8'h59, 8'h2d, 8'h3c};
	logic [6:0] pt [14] = '{7'h41, 7'h43, 7'h45, 7'h40, 7'h47, 7'h20,
		7'h3f, 7'h1e, 7'h1f, 7'h7e, 7'h7f, 7'h00, 7'h60, 7'h50};
	logic [7:0] boot_b [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

	// Identity value is arbitrary
	ira_top #(.CHIP_ID(8'h3c)) DUT (.clock(clock), .rst_n(rst_n),
		.host_port(host_port), .host_rd(host_rd), .host_wr(host_wr),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.serial_busy(serial_busy), .evt_set_first(evt_set_first),
		.evt_set_second(evt_set_second),
		.voltage_id_inputs(voltage_id_inputs), .cfg_out(cfg_out),
		.mgmt_mask_out1(mgmt_mask_out1), .mgmt_mask_out2(mgmt_mask_out2),
		.host_mask_out1(host_mask_out1), .host_mask_out2(host_mask_out2),
		.evt_first_out(evt_first_out), .evt_second_out(evt_second_out),
		.serial_addr_out(serial_addr_out), .fan_div_out(fan_div_out));
	ira_far_model #(.VOLTAGE_ID_INPUTS(4'h9)) far (.clock(clock),
		.serial_busy(serial_busy), .evt_set_first(evt_set_first),
		.evt_set_second(evt_set_second),
		.voltage_id_inputs(voltage_id_inputs));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One strobe per access; read data is settled at the next low edge
	task automatic acc(input logic [2:0] p, input logic w,
		input logic [7:0] d);
		@(negedge clock);
		host_port = p;
		host_wr = w;
		host_rd = ~w;
		host_wdata = d;
		@(negedge clock);
		host_wr = 1'b0;
		host_rd = 1'b0;
	endtask
	task automatic rreg(input logic [6:0] a, input logic [7:0] e);
		acc(IRA_PORT_INDEX, 1'b1, {1'b0, a});
		acc(IRA_PORT_DATA, 1'b0, 8'h00);
		`CHK(host_rdata, e)
	endtask
	task automatic wreg(input logic [6:0] a, input logic [7:0] d);
		acc(IRA_PORT_INDEX, 1'b1, {1'b0, a});
		acc(IRA_PORT_DATA, 1'b1, d);
	endtask
	task automatic idx(input logic [7:0] e);
		acc(IRA_PORT_INDEX, 1'b0, 8'h00);
		`CHK(host_rdata, e)
	endtask
	function automatic logic [6:0] nxt_ptr(input logic [6:0] a);
		if (a == IRA_A_EVT_FIRST || a == IRA_A_MGMT_M1 || a == IRA_A_HOST_M1)
			return a + IRA_PTR_STEP;
		if (a < IRA_BOOT_TOP || (a >= IRA_VAL_HI_BASE && a < IRA_VAL_HI_TOP))
			return a + IRA_PTR_STEP;
		return a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// power-on values
	task automatic t_reset;
		`CHK(host_rdata, 8'h00)
		idx(8'h00);
		for (int i = 0; i < 10; i++)
			rreg(IRA_A_CONFIG + 7'(i), rst_exp[i]);
		`CHK(cfg_out, 8'h08)
		`CHK(mgmt_mask_out2, 8'h00)
		`CHK(host_mask_out1, 8'h00)
		`CHK(host_mask_out2, 8'h40)
	endtask
	task automatic t_busy;
		acc(IRA_PORT_INDEX, 1'b1, 8'h48);
		idx(8'hc8);
		acc(IRA_PORT_DATA, 1'b0, 8'h00);
		idx(8'h48);
		acc(IRA_PORT_INDEX, 1'b1, 8'h48);
		acc(IRA_PORT_DATA, 1'b1, 8'h2d);
		idx(8'h48);
	endtask
	task automatic t_ptr;
		for (int i = 0; i < 14; i++) begin
			acc(IRA_PORT_INDEX, 1'b1, {1'b0, pt[i]});
			acc(IRA_PORT_DATA, 1'b0, 8'h00);
			idx({1'b0, nxt_ptr(pt[i])});
		end
	endtask
	task automatic t_events;
		far.raise_evt(8'ha5, 8'h03);
		`CHK(evt_first_out, 8'ha5)
		rreg(IRA_A_EVT_FIRST, 8'ha5);
		rreg(IRA_A_EVT_FIRST, 8'h00);
		rreg(IRA_A_EVT_SECND, 8'h03);
		`CHK(evt_second_out, 8'h00)
	endtask
	task automatic t_boot;
		for (int i = 0; i < 4; i++)
			acc(i[0] ? IRA_PORT_BOOT_B : IRA_PORT_BOOT_A, 1'b1, boot_b[i]);
		acc(IRA_PORT_INDEX, 1'b1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			acc(IRA_PORT_DATA, 1'b0, 8'h00);
			`CHK(host_rdata, boot_b[i])
		end
		idx(8'h04);
		// Fill the remaining slots; the last one flags an overflow
		for (int i = 0; i < 28; i++)
			acc(IRA_PORT_BOOT_A, 1'b1, 8'h55);
		`CHK(evt_second_out, 8'h20)
	endtask
	task automatic t_serial;
		int n;
		fork
			far.serial_txn(8);
		join_none
		repeat (2) @(negedge clock);
		idx(8'h84);
		for (n = 0; n < 20 && host_rdata[IRA_BUSY_BIT] !== 1'b0; n++)
			acc(IRA_PORT_INDEX, 1'b0, 8'h00);
		if (n == 20) begin
			errors++;
			end_of_test();
		end
		`CHK(host_rdata, 8'h04)
	endtask
	// Access kinds and the initialise bit
	task automatic t_regs;
		wreg(IRA_A_MGMT_M1, 8'h5a);
		rreg(IRA_A_MGMT_M1, 8'h5a);
		`CHK(mgmt_mask_out1, 8'h5a)
		wreg(IRA_A_EVT_FIRST, 8'hff);
		rreg(IRA_A_EVT_FIRST, 8'h00);
		wreg(IRA_A_CHIP_ID, 8'h00);
		rreg(IRA_A_CHIP_ID, 8'h3c);
		rreg(7'h50, 8'h00);
		wreg(IRA_A_VID_FAN, 8'ha0);
		rreg(IRA_A_VID_FAN, 8'ha9);
		`CHK(fan_div_out, 4'ha)
		wreg(IRA_A_SER_ADDR, 8'h11);
		wreg(IRA_A_CONFIG, 8'h80);
		`CHK(mgmt_mask_out1, 8'h00)
		`CHK(fan_div_out, IRA_RST_FAN_DIV)
		`CHK(serial_addr_out, 8'h11)
		rreg(IRA_A_CONFIG, 8'h08);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		checks_done = 0;
		rst_n = 1'b0;
		host_port = 3'h0;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_wdata = 8'h00;
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_busy();
		t_ptr();
		t_events();
		t_boot();
		t_serial();
		t_regs();
		end_of_test();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		end_of_test();
	end
endmodule
